// ==== include/nad_defines.svh ====
`ifndef NAD_DEFINES_SVH
`define NAD_DEFINES_SVH
// Register byte offsets.
`define NAD_OFS_EXEC   6'h00
`define NAD_OFS_ACC    6'h04
`define NAD_OFS_CARRY  6'h08
`define NAD_OFS_ADDR   6'h0c
`define NAD_OFS_MEM    6'h10
`define NAD_OFS_PC     6'h14
`define NAD_OFS_STKT   6'h18
`define NAD_OFS_STKB   6'h1c
`define NAD_OFS_QLAT   6'h20
`define NAD_OFS_EN     6'h24
`define NAD_OFS_GLAT   6'h28
`define NAD_OFS_DOUT   6'h2c
`define NAD_OFS_SHIFT  6'h30
`define NAD_OFS_STAT   6'h34
// Opcodes.
`define NAD_OP_ZERO    8'h00
`define NAD_OP_XOR     8'h02
`define NAD_OP_CSET    8'h22
`define NAD_OP_ASC     8'h30
`define NAD_OP_ADD     8'h31
`define NAD_OP_CCLR    8'h32
`define NAD_OP_COPY    8'h33
`define NAD_OP_COPY2   8'h3c
`define NAD_OP_COMP    8'h40
`define NAD_OP_NOP     8'h44
`define NAD_OP_AIS_HI  4'h5
// Field positions and enable bits.
`define NAD_EN_CNT     0
`define NAD_EN_LOUT    2
`define NAD_ST_SKIP    0
`define NAD_ST_BUSY    1
`define NAD_ST_GIN     2
// Reset values.
`define NAD_RST_NIB    4'h0
`define NAD_RST_PC     9'h000
`define NAD_RST_ADDR   6'h00
// Longest L glitch and its cycle count at 8 ns.
`define NAD_GLITCH_NS  2000
`define NAD_CLK_NS     8
`define NAD_GLITCH_CYC (`NAD_GLITCH_NS / `NAD_CLK_NS)
`endif

// ==== include/nad_pkg.sv ====
package nad_pkg;
    typedef enum logic [2:0] {
        NAD_IDLE   = 3'b001,
        NAD_GLITCH = 3'b010,
        NAD_LOAD   = 3'b100
    } nad_state_e;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [5:0]  address;
        logic [31:0] writedata;
    } nad_bus_req_s;
endpackage

// ==== rtl/nad_datapath.sv ====
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
`include "nad_defines.svh"
// Function
// - Address register is 6 bits: 2-bit row over 4-bit digit; RAM nibble is operand.
// - Program counter and both return save registers are 9 bits wide.
// - An 8-bit latch holds the data driven onto the L port.
// - Provide 4-bit enable register, 4-bit G latch and 4-bit D output.
// - Serial nibble shifts or counts, with a companion logic clock output.
// - Operand fields: 2-bit row, 4-bit digit, 4-bit immediate, 9-bit ROM address.
// - Opcode 30 adds A, carry and RAM; carry out stored and skips.
// - Opcode 31 adds RAM to A, carry untouched, never skips.
// - Opcodes 5y add immediate, skip on carry out, carry untouched.
// - Opcode 40 complements A, no skip, carry untouched.
// - Opcode 02 XORs RAM into A, no skip.
// - Copy-to-latch first loads the second opcode byte into L, then data.
// - Reduced-pin variant omits D2, D3 and G3.
// - Reset clears PC, A, address, carry, D, enable, G; RAM kept.
module nad_datapath #(
    parameter bit REDUCED_PINS = 1'b0
) (
    // Clock and reset.
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    // Avalon-MM slave.
    input  wire nad_pkg::nad_bus_req_s bus_req,
    output logic [31:0]               readdata,
    output logic                      waitrequest,
    // Port pins.
    output logic [7:0]                l_out,
    output logic                      l_oe,
    output logic [3:0]                g_out,
    input  wire logic [3:0]           g_in,
    output logic [3:0]                d_out,
    input  wire logic                 serial_in,
    output logic                      logic_clock_out
);
    generate
        if (`NAD_GLITCH_CYC < 1) begin : g_bad_clock
            $error("glitch bound shorter than one clock cycle");
        end
    endgenerate

    nad_pkg::nad_state_e state_reg;
    nad_pkg::nad_state_e state_next;

    logic [3:0] acc_reg;
    logic       carry_reg;
    logic [5:0] addr_reg;
    logic [8:0] pc_reg;
    logic [8:0] stack_top_reg;
    logic [8:0] stack_bot_reg;
    logic [7:0] latch_reg;
    logic [3:0] en_reg;
    logic [3:0] g_reg;
    logic [3:0] d_reg;
    logic [3:0] shift_reg;
    logic       skip_reg;
    logic [7:0] last_op_reg;
    logic       wait_reg;
    logic [31:0] rdata_reg;
    logic       clk_out_reg;
    logic [3:0] g_meta_reg;
    logic [3:0] g_sync_reg;
    logic       si_meta_reg;
    logic       si_sync_reg;
    logic       si_prev_reg;
    logic [3:0] ram [0:63];

    // Address register split and addressed nibble.
    wire [1:0] ram_row_select   = addr_reg[5:4];
    wire [3:0] ram_digit_select = addr_reg[3:0];
    wire [3:0] mem_nib          = ram[{ram_row_select, ram_digit_select}];

    // Bus decode.
    wire       req       = bus_req.read | bus_req.write;
    wire       busy      = (state_reg != nad_pkg::NAD_IDLE);
    wire       accept    = req & wait_reg & ~busy;
    wire       wr_done   = bus_req.write & ~wait_reg;
    wire [5:0] ofs       = bus_req.address;
    wire [7:0] wr_byte   = bus_req.writedata[7:0];
    wire       exec      = wr_done & (ofs == `NAD_OFS_EXEC);
    wire [7:0] opcode    = wr_byte;
    wire [3:0] imm       = opcode[3:0];

    // Instruction decode.
    wire op_asc  = (opcode == `NAD_OP_ASC);
    wire op_add  = (opcode == `NAD_OP_ADD);
    wire op_ais  = (opcode[7:4] == `NAD_OP_AIS_HI);
    wire op_zero = (opcode == `NAD_OP_ZERO);
    wire op_comp = (opcode == `NAD_OP_COMP);
    wire op_xor  = (opcode == `NAD_OP_XOR);
    wire op_cset = (opcode == `NAD_OP_CSET);
    wire op_cclr = (opcode == `NAD_OP_CCLR);
    wire op_copy = (opcode == `NAD_OP_COPY);

    wire [4:0] sum_asc = {1'b0, acc_reg} + {4'h0, carry_reg} + {1'b0, mem_nib};
    wire [4:0] sum_add = {1'b0, acc_reg} + {1'b0, mem_nib};
    wire [4:0] sum_ais = {1'b0, acc_reg} + {1'b0, imm};

    wire [3:0] acc_exec = op_asc  ? sum_asc[3:0] :
                          op_add  ? sum_add[3:0] :
                          op_ais  ? sum_ais[3:0] :
                          op_zero ? `NAD_RST_NIB :
                          op_comp ? ~acc_reg :
                          op_xor  ? (acc_reg ^ mem_nib) :
                          acc_reg;
    wire       carry_exec = op_asc  ? sum_asc[4] :
                            op_cset ? 1'b1 :
                            op_cclr ? 1'b0 :
                            carry_reg;
    // A zero immediate never carries, so that form simply leaves A alone.
    wire       skip_exec  = (op_asc & sum_asc[4]) | (op_ais & sum_ais[4]);
    wire [8:0] pc_exec    = pc_reg + {7'h00, op_copy, ~op_copy} + {8'h00, skip_exec};

    // Shift or count the serial nibble.
    wire       si_fall    = si_prev_reg & ~si_sync_reg;
    wire [3:0] shift_step = en_reg[`NAD_EN_CNT] ?
                            (si_fall ? shift_reg + 4'h1 : shift_reg) :
                            (exec ? {shift_reg[2:0], si_sync_reg} : shift_reg);

    wire [3:0] pin_mask = REDUCED_PINS ? 4'h3 : 4'hf;
    wire [3:0] g_mask   = REDUCED_PINS ? 4'h7 : 4'hf;

    wire [31:0] rd_word =
        (ofs == `NAD_OFS_EXEC)  ? {24'h0, last_op_reg} :
        (ofs == `NAD_OFS_ACC)   ? {28'h0, acc_reg} :
        (ofs == `NAD_OFS_CARRY) ? {31'h0, carry_reg} :
        (ofs == `NAD_OFS_ADDR)  ? {26'h0, addr_reg} :
        (ofs == `NAD_OFS_MEM)   ? {28'h0, mem_nib} :
        (ofs == `NAD_OFS_PC)    ? {23'h0, pc_reg} :
        (ofs == `NAD_OFS_STKT)  ? {23'h0, stack_top_reg} :
        (ofs == `NAD_OFS_STKB)  ? {23'h0, stack_bot_reg} :
        (ofs == `NAD_OFS_QLAT)  ? {24'h0, latch_reg} :
        (ofs == `NAD_OFS_EN)    ? {28'h0, en_reg} :
        (ofs == `NAD_OFS_GLAT)  ? {28'h0, g_reg} :
        (ofs == `NAD_OFS_DOUT)  ? {28'h0, d_reg} :
        (ofs == `NAD_OFS_SHIFT) ? {28'h0, shift_reg} :
        (ofs == `NAD_OFS_STAT)  ? {26'h0, g_sync_reg, busy, skip_reg} :
        32'h0;

    // The L pins run one cycle ahead of the latch during a copy: glitch byte first, then the copied data.
    wire [7:0] l_next = (state_next == nad_pkg::NAD_GLITCH) ? `NAD_OP_COPY2 :
                        (state_reg != nad_pkg::NAD_IDLE) ? {acc_reg, mem_nib} :
                        (wr_done && ofs == `NAD_OFS_QLAT) ? wr_byte : latch_reg;

    always_comb begin
        case (state_reg)
            nad_pkg::NAD_IDLE:   state_next = (exec & op_copy) ? nad_pkg::NAD_GLITCH
                                                                : nad_pkg::NAD_IDLE;
            nad_pkg::NAD_GLITCH: state_next = nad_pkg::NAD_LOAD;
            nad_pkg::NAD_LOAD:   state_next = nad_pkg::NAD_IDLE;
            default:             state_next = nad_pkg::NAD_IDLE;
        endcase
    end

    // Bus handshake: one wait cycle, longer while a copy is in flight.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0;
        end else begin
            wait_reg  <= ~accept;
            rdata_reg <= accept ? rd_word : rdata_reg;
        end
    end

    // Pin synchronisers.
    always_ff @(posedge clock) begin
        g_meta_reg  <= g_in;
        g_sync_reg  <= g_meta_reg;
        si_meta_reg <= serial_in;
        si_sync_reg <= si_meta_reg;
        si_prev_reg <= si_sync_reg;
    end

    // Software may load RAM at the current address.
    always_ff @(posedge clock) begin
        if (wr_done && ofs == `NAD_OFS_MEM) begin
            ram[addr_reg] <= wr_byte[3:0];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg     <= nad_pkg::NAD_IDLE;
            acc_reg       <= `NAD_RST_NIB;
            carry_reg     <= 1'b0;
            addr_reg      <= `NAD_RST_ADDR;
            pc_reg        <= `NAD_RST_PC;
            en_reg        <= `NAD_RST_NIB;
            g_reg         <= `NAD_RST_NIB;
            d_reg         <= `NAD_RST_NIB;
            stack_top_reg <= `NAD_RST_PC;
            stack_bot_reg <= `NAD_RST_PC;
            latch_reg     <= 8'h00;
            shift_reg     <= `NAD_RST_NIB;
            skip_reg      <= 1'b0;
            last_op_reg   <= 8'h00;
        end else begin
            state_reg <= state_next;
            shift_reg <= (wr_done && ofs == `NAD_OFS_SHIFT) ? wr_byte[3:0] : shift_step;
            if (exec) begin
                acc_reg     <= acc_exec;
                carry_reg   <= carry_exec;
                skip_reg    <= skip_exec;
                pc_reg      <= pc_exec;
                last_op_reg <= opcode;
            end
            if (state_reg == nad_pkg::NAD_GLITCH) begin
                latch_reg <= `NAD_OP_COPY2;
            end else if (state_reg == nad_pkg::NAD_LOAD) begin
                latch_reg <= {acc_reg, mem_nib};
            end else if (wr_done && ofs == `NAD_OFS_QLAT) begin
                latch_reg <= wr_byte;
            end
            if (wr_done) begin
                case (ofs)
                    `NAD_OFS_ACC:   acc_reg       <= wr_byte[3:0];
                    `NAD_OFS_CARRY: carry_reg     <= wr_byte[0];
                    `NAD_OFS_ADDR:  addr_reg      <= wr_byte[5:0];
                    `NAD_OFS_PC:    pc_reg        <= bus_req.writedata[8:0];
                    `NAD_OFS_STKT:  stack_top_reg <= bus_req.writedata[8:0];
                    `NAD_OFS_STKB:  stack_bot_reg <= bus_req.writedata[8:0];
                    `NAD_OFS_EN:    en_reg        <= wr_byte[3:0];
                    `NAD_OFS_GLAT:  g_reg         <= wr_byte[3:0];
                    `NAD_OFS_DOUT:  d_reg         <= wr_byte[3:0];
                    default:        ;
                endcase
            end
        end
    end

    // Registered pin drivers.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            l_out       <= 8'h00;
            l_oe        <= 1'b0;
            g_out       <= 4'h0;
            d_out       <= 4'h0;
            clk_out_reg <= 1'b0;
        end else begin
            l_out       <= l_next;
            l_oe        <= en_reg[`NAD_EN_LOUT];
            g_out       <= g_reg & g_mask;
            d_out       <= d_reg & pin_mask;
            clk_out_reg <= en_reg[`NAD_EN_CNT] ? 1'b0 : ~clk_out_reg;
        end
    end

    assign readdata        = rdata_reg;
    assign waitrequest     = wait_reg;
    assign logic_clock_out = clk_out_reg;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    a_asc_sum_carry: assert property (exec && op_asc |=>
        acc_reg == $past(sum_asc[3:0]) && carry_reg == $past(sum_asc[4])
        && skip_reg == $past(sum_asc[4]))
        else $error("carry add result wrong");
    a_add_no_carry: assert property (exec && op_add |=>
        carry_reg == $past(carry_reg) && !skip_reg && acc_reg == $past(sum_add[3:0]))
        else $error("plain add touched carry or skipped");
    a_ais_skip_only: assert property (exec && op_ais |=>
        skip_reg == $past(sum_ais[4]) && carry_reg == $past(carry_reg))
        else $error("immediate add skip wrong");
    a_comp_acc: assert property (exec && op_comp |=>
        acc_reg == ~$past(acc_reg) && !skip_reg && $stable(carry_reg))
        else $error("complement wrong");
    a_xor_acc: assert property (exec && op_xor |=>
        acc_reg == ($past(acc_reg) ^ $past(mem_nib)) && !skip_reg)
        else $error("xor wrong");
    a_copy_glitch: assert property (exec && op_copy |=>
        l_out == `NAD_OP_COPY2 ##1 l_out == {acc_reg, mem_nib} ##1 latch_reg == l_out)
        else $error("copy sequence wrong");
    a_pc_advance: assert property (exec |=>
        pc_reg == 9'($past(pc_reg) + ($past(op_copy) ? 9'h2 : 9'h1) + {8'h00, skip_reg}))
        else $error("pc step wrong");
    a_small_ops: assert property (exec && (op_cset || op_cclr) |=>
        carry_reg == $past(op_cset) && !skip_reg)
        else $error("carry set or clear wrong");
    a_reduced_pins: assert property (d_out == ($past(d_reg) & pin_mask)
        && g_out == ($past(g_reg) & g_mask)
        && (!REDUCED_PINS || (d_out[3:2] == 2'b00 && !g_out[3])))
        else $error("omitted pins driven");
    a_reset_clear: assert property (disable iff (1'b0) sys_rst |=>
        pc_reg == `NAD_RST_PC && acc_reg == 4'h0 && !carry_reg && addr_reg == 6'h00
        && en_reg == 4'h0 && g_reg == 4'h0 && d_reg == 4'h0)
        else $error("reset clear missing");
    a_ais_acc: assert property (exec && op_ais |=>
        acc_reg == $past(sum_ais[3:0]))
        else $error("immediate add result wrong");
    a_zero_acc: assert property (exec && op_zero |=>
        acc_reg == 4'h0 && !skip_reg && $stable(carry_reg))
        else $error("clear accumulator wrong");
    a_nop_hold: assert property (exec && opcode == `NAD_OP_NOP |=>
        $stable(acc_reg) && $stable(carry_reg) && !skip_reg)
        else $error("no operation changed state");
    a_shift_count: assert property (en_reg[`NAD_EN_CNT] && si_fall
        && !(wr_done && ofs == `NAD_OFS_SHIFT) |=> shift_reg == 4'($past(shift_reg) + 4'h1))
        else $error("counter missed a falling edge");
endmodule

// ==== sim/nad_datapath_test.sv ====
`timescale 1ns/10ps
`include "nad_defines.svh"
module nad_datapath_test;
    logic                  clock;
    logic                  sys_rst;
    nad_pkg::nad_bus_req_s bus_req;
    logic [31:0]           readdata;
    logic                  waitrequest;
    logic [7:0]            l_out;
    logic                  l_oe;
    logic [3:0]            g_out;
    logic [3:0]            g_in;
    logic [3:0]            d_out;
    logic                  serial_in;
    logic                  logic_clock_out;
    int                    errors;
    int                    comparisons;
    logic [31:0]           seed;
    logic [31:0]           exp_q[$];
    logic [8:0]            pc_exp;
    logic [7:0]            ops[9] = '{`NAD_OP_ZERO, `NAD_OP_XOR, `NAD_OP_CSET, `NAD_OP_ASC,
                                      `NAD_OP_ADD, `NAD_OP_CCLR, `NAD_OP_COMP, `NAD_OP_NOP, 8'h50};

    nad_datapath #(.REDUCED_PINS(1'b0)) nad_datapath_i (
        .clock(clock), .sys_rst(sys_rst), .bus_req(bus_req), .readdata(readdata),
        .waitrequest(waitrequest), .l_out(l_out), .l_oe(l_oe), .g_out(g_out), .g_in(g_in),
        .d_out(d_out), .serial_in(serial_in), .logic_clock_out(logic_clock_out));

    initial clock = 1'b0;
    always #4 clock = ~clock;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Returns {skip, carry, accumulator} after one arithmetic opcode.
    function automatic logic [5:0] model(logic [7:0] op, logic [3:0] a, logic c, logic [3:0] m);
        logic [4:0] s;
        logic       sk;
        sk = 1'b0;
        if (op == `NAD_OP_ZERO) a = 4'h0;
        else if (op == `NAD_OP_XOR) a = a ^ m;
        else if (op == `NAD_OP_CSET) c = 1'b1;
        else if (op == `NAD_OP_CCLR) c = 1'b0;
        else if (op == `NAD_OP_COMP) a = ~a;
        else if (op == `NAD_OP_ASC) begin
            s = {1'b0, a} + {4'h0, c} + {1'b0, m};
            a = s[3:0];
            c = s[4];
            sk = s[4];
        end else if (op == `NAD_OP_ADD) a = a + m;
        else if (op[7:4] == `NAD_OP_AIS_HI) begin
            s = {1'b0, a} + {1'b0, op[3:0]};
            a = s[3:0];
            sk = s[4];
        end
        return {sk, c, a};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic close_out();
        if (errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // The request stands until a rising edge samples waitrequest low.
    task automatic wait_ack();
        do @(posedge clock); while (waitrequest !== 1'b0);
    endtask

    task automatic bus_write(input logic [5:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_req.write     <= 1'b1;
        bus_req.address   <= a;
        bus_req.writedata <= d;
        wait_ack();
        bus_req.write <= 1'b0;
    endtask

    task automatic bus_read(input logic [5:0] a, input logic [31:0] want);
        exp_q.push_back(want);
        @(posedge clock);
        bus_req.read    <= 1'b1;
        bus_req.address <= a;
        wait_ack();
        bus_req.read <= 1'b0;
    endtask

    always @(posedge clock) begin
        if (bus_req.read === 1'b1 && waitrequest === 1'b0) begin
            if (exp_q.size() == 0) check(readdata, 32'hffffffff);
            else check(readdata, exp_q.pop_front());
        end
    end

    task automatic do_reset();
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        pc_exp = 9'h000;
    endtask

    task automatic reset_values();
        logic [5:0] regs[7] = '{`NAD_OFS_ACC, `NAD_OFS_CARRY, `NAD_OFS_ADDR, `NAD_OFS_PC,
                                `NAD_OFS_EN, `NAD_OFS_GLAT, `NAD_OFS_DOUT};
        foreach (regs[i]) bus_read(regs[i], 32'h0);
        check({g_out, d_out, l_oe}, 32'h0);
    endtask

    initial begin
        #200000;
        errors++;
        close_out();
    end

    initial begin
        logic [7:0]  op;
        logic [3:0]  a;
        logic [3:0]  m;
        logic        c;
        logic [5:0]  r;
        logic [7:0]  fin;
        logic [7:0]  prev;
        logic        p;
        errors = 0;
        comparisons = 0;
        seed = 32'd73;
        sys_rst = 1'b1;
        bus_req = '0;
        g_in = 4'h0;
        serial_in = 1'b0;
        do_reset();
        g_in <= 4'(rnd());
        reset_values();
        bus_write(`NAD_OFS_EXEC, {24'h0, `NAD_OP_ZERO});
        pc_exp = 9'h001;
        bus_write(`NAD_OFS_ADDR, 32'hff);
        bus_read(`NAD_OFS_ADDR, 32'h3f);
        bus_write(`NAD_OFS_MEM, 32'h9);
        bus_write(`NAD_OFS_ADDR, 32'h2f);
        bus_write(`NAD_OFS_MEM, 32'h6);
        bus_write(`NAD_OFS_ADDR, 32'h3f);
        bus_read(`NAD_OFS_MEM, 32'h9);
        for (int i = 0; i < 40; i++) begin
            op = ops[rnd() % 9];
            if (op == 8'h50) op[3:0] = 4'h1 + 4'(rnd() % 15);
            a = 4'(rnd());
            c = 1'(rnd());
            m = 4'(rnd());
            serial_in <= 1'(rnd());
            bus_write(`NAD_OFS_ACC, {28'h0, a});
            bus_write(`NAD_OFS_CARRY, {31'h0, c});
            bus_write(`NAD_OFS_MEM, {28'h0, m});
            bus_write(`NAD_OFS_EXEC, {24'h0, op});
            r = model(op, a, c, m);
            pc_exp = pc_exp + 9'd1 + {8'h0, r[5]};
            bus_read(`NAD_OFS_ACC, {28'h0, r[3:0]});
            bus_read(`NAD_OFS_CARRY, {31'h0, r[4]});
            bus_read(`NAD_OFS_STAT, {26'h0, g_in, 1'b0, r[5]});
            bus_read(`NAD_OFS_PC, {23'h0, pc_exp});
            bus_read(`NAD_OFS_EXEC, {24'h0, op});
        end
        bus_write(`NAD_OFS_GLAT, 32'hf);
        bus_write(`NAD_OFS_DOUT, 32'ha);
        repeat (2) @(negedge clock);
        check({g_out, d_out}, 32'hfa);
        bus_read(`NAD_OFS_GLAT, 32'hf);
        bus_read(6'h3c, 32'h0);
        bus_write(`NAD_OFS_STAT, 32'hffffffff);
        bus_read(`NAD_OFS_STAT, {26'h0, g_in, 1'b0, r[5]});
        bus_write(`NAD_OFS_EN, 32'h0);
        @(negedge clock);
        p = logic_clock_out;
        repeat (4) begin
            @(negedge clock);
            check({31'h0, logic_clock_out}, {31'h0, ~p});
            p = logic_clock_out;
        end
        bus_write(`NAD_OFS_EN, 32'h5);
        repeat (2) @(negedge clock);
        check({31'h0, logic_clock_out}, 32'h0);
        a = 4'(rnd());
        m = 4'(rnd());
        fin = {a, m};
        bus_write(`NAD_OFS_ACC, {28'h0, a});
        bus_write(`NAD_OFS_MEM, {28'h0, m});
        prev = l_out;
        bus_write(`NAD_OFS_EXEC, {24'h0, `NAD_OP_COPY});
        pc_exp = pc_exp + 9'd2;
        repeat (6) begin
            @(negedge clock);
            check(l_out === 8'h3c || l_out === fin || l_out === prev, 32'h1);
        end
        check({l_oe, l_out}, {23'h0, 1'b1, fin});
        bus_read(`NAD_OFS_QLAT, {24'h0, fin});
        bus_read(`NAD_OFS_PC, {23'h0, pc_exp});
        bus_write(`NAD_OFS_SHIFT, 32'h0);
        repeat (3) begin
            serial_in <= 1'b1;
            repeat (4) @(posedge clock);
            serial_in <= 1'b0;
            repeat (4) @(posedge clock);
        end
        bus_read(`NAD_OFS_SHIFT, 32'h3);
        bus_write(`NAD_OFS_ADDR, 32'h15);
        bus_write(`NAD_OFS_MEM, 32'hc);
        do_reset();
        reset_values();
        bus_write(`NAD_OFS_ADDR, 32'h15);
        bus_read(`NAD_OFS_MEM, 32'hc);
        repeat (4) @(posedge clock);
        close_out();
    end
endmodule
